// ===== src/line_iface_hw_config_decode.sv
/*
  Hardware-control configuration decoder for a single-channel line interface.
  Static pins are synchronised, decoded into datapath settings and held in
  flip-flops; register settings replace them outside hardware control.
  Assumes pins change only during reconfiguration.
*/
// Behaviour
// - mode pins pick hardware, serial, Motorola-style or Intel-style control
// - termination pin only flags external matching as illegal for T1/J1 tx in ext_match_illegal; no matching setting is output
// - format pins pick HDB3/B8ZS single rail, AMI single rail, dual rail, slicer
// - template 0000 and 0001 give E1 at 75 and 120 ohm
// - templates 0010 to 0110 give DSX1 100 ohm in five cable ranges
// - template 0111 gives J1 at 110 ohm, 0 to 655 ft
// - templates 1000 to 1011 give DS1 build-out 0 to -22.5 dB; above, DS1
// - equalizer pin gives 10 dB short haul or 36 dB long haul reach
// - receiver power-down pin powers the receiver down when high
// - pattern pins give normal, all ones, PRBS or transmitter power down
// - jitter attenuator off, rx broad 64, rx narrow 128, tx narrow 128
// - monitor gain pin adds up to 26 dB receive gain when high
// - loopback pins give none, analog, digital or remote loopback
// - driver high-impedance pin disables the line driver when high
// - clock edge pin picks rising or falling active receive edge
// - E1 loss of signal after 32 or 2048 consecutive zeros
// - T1/J1 loss of signal after 175 or 1544 consecutive zeros
// - loss of signal clears only at 12.5 percent ones density
// - receive latency without attenuator: 7 UI single rail, 2 UI dual rail
`timescale 1ns/1ps
module line_iface_hw_config_decode (
  input wire logic sys_clk,
  input wire logic rst,
  input line_cfg_pkg::cfg_pins_t cfg_pins,
  input line_cfg_pkg::cfg_pins_t reg_cfg,
  input wire logic los_long_criterion,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  output line_cfg_pkg::cfg_decoded_t cfg_out,
  output logic [1:0] ctrl_iface,
  output logic hw_control,
  output logic [11:0] los_zero_limit,
  output logic [3:0] rx_latency_ui,
  output logic los
);
  import line_cfg_pkg::*;

  cfg_pins_t pins_meta_r;
  cfg_pins_t pins_sync_r;
  cfg_pins_t sel_cfg;
  cfg_decoded_t dec_nxt;
  cfg_decoded_t cfg_r;
  logic [1:0] ctrl_iface_r;
  logic hw_control_r;
  logic [11:0] los_limit_r;
  logic [11:0] los_limit_nxt;
  logic [3:0] latency_r;
  logic [3:0] latency_nxt;
  logic los_r;
  logic los_int;

  // =====================================================================
  // pin synchroniser
  // =====================================================================
  // two stages; the first stage feeds nothing but the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins_meta_r <= '0;
      pins_sync_r <= '0;
    end else begin
      pins_meta_r <= cfg_pins;
      pins_sync_r <= pins_meta_r;
    end
  end

  // =====================================================================
  // control interface select and source choice
  // =====================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_iface_r <= CTRL_HW;
      hw_control_r <= 1'b1;
    end else begin
      ctrl_iface_r <= pins_sync_r.ctrl_mode;
      hw_control_r <= (pins_sync_r.ctrl_mode == CTRL_HW);
    end
  end

  // mode pins are always live; the rest follow registers off hardware control
  always_comb begin
    if (pins_sync_r.ctrl_mode == CTRL_HW) begin
      sel_cfg = pins_sync_r;
    end else begin
      sel_cfg = reg_cfg;
      sel_cfg.ctrl_mode = pins_sync_r.ctrl_mode;
    end
  end

  // =====================================================================
  // decode
  // =====================================================================
  always_comb begin
    dec_nxt = '0;
    dec_nxt.line_std = STD_DS1;
    dec_nxt.term_ohms = OHM_100;
    // pulse template
    if (sel_cfg.pulse_template_select == PT_E1_75) begin
      dec_nxt.line_std = STD_E1;
      dec_nxt.term_ohms = OHM_75;
    end else if (sel_cfg.pulse_template_select == PT_E1_120) begin
      dec_nxt.line_std = STD_E1;
      dec_nxt.term_ohms = OHM_120;
    end else if (sel_cfg.pulse_template_select <= PT_DSX1_LAST) begin
      dec_nxt.line_std = STD_DSX1;
      dec_nxt.dsx1_range = 3'(sel_cfg.pulse_template_select - PT_DSX1_FIRST);
    end else if (sel_cfg.pulse_template_select == PT_J1) begin
      dec_nxt.line_std = STD_J1;
      dec_nxt.term_ohms = OHM_110;
    end else if (sel_cfg.pulse_template_select <= PT_DS1_LBO_LAST) begin
      dec_nxt.lbo_half_db = 6'((sel_cfg.pulse_template_select - PT_DS1_LBO_FIRST)
                               * LBO_STEP_HALF_DB);
    end
    // equalizer reach and monitor gain
    dec_nxt.eq_reach_db = sel_cfg.equalizer_reach_select ? EQ_LONG_DB : EQ_SHORT_DB;
    dec_nxt.mon_gain_db = sel_cfg.monitor_gain_select ? MON_GAIN_DB : 5'h00;
    dec_nxt.rx_pd = sel_cfg.receiver_powerdown;
    // transmit pattern
    dec_nxt.tx_send_ones = (sel_cfg.tx_pattern_select == PAT_ONES);
    dec_nxt.tx_send_prbs = (sel_cfg.tx_pattern_select == PAT_PRBS);
    dec_nxt.tx_pd = (sel_cfg.tx_pattern_select == PAT_TX_PD);
    // jitter attenuator
    unique case (sel_cfg.jitter_atten_config)
      JA_OFF: begin
        dec_nxt.ja_depth = 8'h00;
      end
      JA_RX_BROAD: begin
        dec_nxt.ja_enable = 1'b1;
        dec_nxt.ja_depth = JA_DEPTH_64;
      end
      JA_RX_NARROW: begin
        dec_nxt.ja_enable = 1'b1;
        dec_nxt.ja_narrow = 1'b1;
        dec_nxt.ja_depth = JA_DEPTH_128;
      end
      JA_TX_NARROW: begin
        dec_nxt.ja_enable = 1'b1;
        dec_nxt.ja_narrow = 1'b1;
        dec_nxt.ja_in_tx = 1'b1;
        dec_nxt.ja_depth = JA_DEPTH_128;
      end
    endcase
    // system interface
    dec_nxt.single_rail = (sel_cfg.system_iface_format == FMT_SR_HDB3) ||
                          (sel_cfg.system_iface_format == FMT_SR_AMI);
    dec_nxt.ami_coding = (sel_cfg.system_iface_format == FMT_SR_AMI);
    dec_nxt.slicer = (sel_cfg.system_iface_format == FMT_SLICER);
    dec_nxt.loopback = sel_cfg.loopback_select;
    dec_nxt.driver_enable = !sel_cfg.driver_hiz;
    dec_nxt.rx_falling_edge = sel_cfg.rx_clock_edge_select;
    // external matching is refused for the T1/J1 transmitter: flag it in
    // ext_match_illegal only; no termination setting is decoded or passed on
    if (!sel_cfg.termination_internal && dec_nxt.line_std != STD_E1) begin
      dec_nxt.ext_match_illegal = 1'b1;
    end
  end

  always_comb begin
    if (dec_nxt.line_std == STD_E1) begin
      los_limit_nxt = los_long_criterion ? LOS_E1_I431 : LOS_E1_G775;
    end else begin
      los_limit_nxt = los_long_criterion ? LOS_T1_I431 : LOS_T1_T1231;
    end
    if (dec_nxt.single_rail || dec_nxt.slicer) begin
      latency_nxt = LAT_SINGLE_UI;
    end else begin
      latency_nxt = LAT_DUAL_UI;
    end
  end

  // =====================================================================
  // decoded settings register
  // =====================================================================
  // outputs are registered so a pin edge moves every field on the same clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
      cfg_r.line_std <= STD_E1;
      cfg_r.term_ohms <= OHM_75;
      cfg_r.eq_reach_db <= EQ_SHORT_DB;
      cfg_r.single_rail <= 1'b1;
      cfg_r.driver_enable <= 1'b1;
      los_limit_r <= LOS_E1_G775;
      latency_r <= LAT_SINGLE_UI;
    end else begin
      cfg_r <= dec_nxt;
      los_limit_r <= los_limit_nxt;
      latency_r <= latency_nxt;
    end
  end

  // =====================================================================
  // loss of signal
  // =====================================================================
  los_detect u_los (
    .sys_clk(sys_clk),
    .rst(rst),
    .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit),
    .zero_limit(los_limit_r),
    .los(los_int)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      los_r <= 1'b0;
    end else begin
      los_r <= los_int;
    end
  end

  assign cfg_out = cfg_r;
  assign ctrl_iface = ctrl_iface_r;
  assign hw_control = hw_control_r;
  assign los_zero_limit = los_limit_r;
  assign rx_latency_ui = latency_r;
  assign los = los_r;

endmodule // line_iface_hw_config_decode

// ===== src/line_cfg_pkg.sv
/*
  Shared types and constants for the hardware-control configuration decoder.
  Assumes a single 100 MHz system clock and an active-high asynchronous reset.
*/
package line_cfg_pkg;

  // =====================================================================
  // control interface and pin codes
  // =====================================================================
  localparam logic [1:0] CTRL_HW = 2'h0;
  localparam logic [1:0] CTRL_SERIAL = 2'h1;
  localparam logic [1:0] CTRL_PAR_MOTO = 2'h2;
  localparam logic [1:0] CTRL_PAR_INTEL = 2'h3;

  localparam logic [1:0] FMT_SR_HDB3 = 2'h0;
  localparam logic [1:0] FMT_SR_AMI = 2'h1;
  localparam logic [1:0] FMT_DUAL = 2'h2;
  localparam logic [1:0] FMT_SLICER = 2'h3;

  localparam logic [3:0] PT_E1_75 = 4'h0;
  localparam logic [3:0] PT_E1_120 = 4'h1;
  localparam logic [3:0] PT_DSX1_FIRST = 4'h2;
  localparam logic [3:0] PT_DSX1_LAST = 4'h6;
  localparam logic [3:0] PT_J1 = 4'h7;
  localparam logic [3:0] PT_DS1_LBO_FIRST = 4'h8;
  localparam logic [3:0] PT_DS1_LBO_LAST = 4'hB;

  localparam logic [1:0] PAT_NORMAL = 2'h0;
  localparam logic [1:0] PAT_ONES = 2'h1;
  localparam logic [1:0] PAT_PRBS = 2'h2;
  localparam logic [1:0] PAT_TX_PD = 2'h3;

  localparam logic [1:0] JA_OFF = 2'h0;
  localparam logic [1:0] JA_RX_BROAD = 2'h1;
  localparam logic [1:0] JA_RX_NARROW = 2'h2;
  localparam logic [1:0] JA_TX_NARROW = 2'h3;
  localparam logic [7:0] JA_DEPTH_64 = 8'h40;
  localparam logic [7:0] JA_DEPTH_128 = 8'h80;

  localparam logic [1:0] LB_NONE = 2'h0;
  localparam logic [1:0] LB_ANALOG = 2'h1;
  localparam logic [1:0] LB_DIGITAL = 2'h2;
  localparam logic [1:0] LB_REMOTE = 2'h3;

  // =====================================================================
  // line standards, terminations, reach figures
  // =====================================================================
  typedef enum logic [3:0] {
    STD_E1 = 4'h1,
    STD_DSX1 = 4'h2,
    STD_J1 = 4'h4,
    STD_DS1 = 4'h8
  } line_std_t;

  localparam logic [7:0] OHM_75 = 8'h4B;
  localparam logic [7:0] OHM_100 = 8'h64;
  localparam logic [7:0] OHM_110 = 8'h6E;
  localparam logic [7:0] OHM_120 = 8'h78;
  localparam logic [5:0] EQ_SHORT_DB = 6'h0A;
  localparam logic [5:0] EQ_LONG_DB = 6'h24;
  localparam logic [4:0] MON_GAIN_DB = 5'h1A;
  // build-out in half-dB steps: 0, 7.5, 15.0, 22.5 dB
  localparam logic [5:0] LBO_STEP_HALF_DB = 6'h0F;

  // =====================================================================
  // loss of signal and latency counts
  // =====================================================================
  localparam logic [11:0] LOS_E1_G775 = 12'h020;
  localparam logic [11:0] LOS_E1_I431 = 12'h800;
  localparam logic [11:0] LOS_T1_T1231 = 12'h0AF;
  localparam logic [11:0] LOS_T1_I431 = 12'h608;
  // 12.5 percent ones density judged over an eight-bit window
  localparam logic [3:0] DENS_WINDOW = 4'h8;
  localparam logic [3:0] DENS_MIN_ONES = 4'h1;
  localparam logic [3:0] LAT_SINGLE_UI = 4'h7;
  localparam logic [3:0] LAT_DUAL_UI = 4'h2;

  // =====================================================================
  // carriers
  // =====================================================================
  typedef struct packed {
    logic [1:0] ctrl_mode;
    logic termination_internal;
    logic [1:0] system_iface_format;
    logic [3:0] pulse_template_select;
    logic equalizer_reach_select;
    logic receiver_powerdown;
    logic [1:0] tx_pattern_select;
    logic [1:0] jitter_atten_config;
    logic monitor_gain_select;
    logic [1:0] loopback_select;
    logic driver_hiz;
    logic rx_clock_edge_select;
  } cfg_pins_t;

  typedef struct packed {
    line_std_t line_std;
    logic [7:0] term_ohms;
    logic [2:0] dsx1_range;
    logic [5:0] lbo_half_db;
    logic [5:0] eq_reach_db;
    logic [4:0] mon_gain_db;
    logic rx_pd;
    logic tx_pd;
    logic tx_send_ones;
    logic tx_send_prbs;
    logic ja_enable;
    logic ja_in_tx;
    logic ja_narrow;
    logic [7:0] ja_depth;
    logic single_rail;
    logic ami_coding;
    logic slicer;
    logic [1:0] loopback;
    logic driver_enable;
    logic rx_falling_edge;
    logic ext_match_illegal;
  } cfg_decoded_t;

endpackage

// ===== src/los_detect.sv
/*
  Zero-run loss-of-signal detector with ones-density recovery.
  Assumes one received bit qualified per rx_bit_valid, synchronous to sys_clk.
*/
`timescale 1ns/1ps
module los_detect (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input wire logic [11:0] zero_limit,
  output logic los
);
  import line_cfg_pkg::*;

  logic [11:0] zero_run_r;
  logic [3:0] win_cnt_r;
  logic [3:0] win_ones_r;
  logic los_r;

  // =====================================================================
  // consecutive zero counter
  // =====================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      zero_run_r <= 12'h000;
    end else if (rx_bit_valid) begin
      if (rx_bit) begin
        zero_run_r <= 12'h000;
      end else if (zero_run_r != 12'hFFF) begin
        zero_run_r <= zero_run_r + 12'h001;
      end
    end
  end

  // =====================================================================
  // ones density window, eight bits at a time
  // =====================================================================
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_cnt_r <= 4'h0;
      win_ones_r <= 4'h0;
    end else if (rx_bit_valid) begin
      if (win_cnt_r == DENS_WINDOW - 4'h1) begin
        win_cnt_r <= 4'h0;
        win_ones_r <= 4'h0;
      end else begin
        win_cnt_r <= win_cnt_r + 4'h1;
        win_ones_r <= win_ones_r + {3'h0, rx_bit};
      end
    end
  end

  // declare wins over clear when both land on the same bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      los_r <= 1'b0;
    end else if (rx_bit_valid) begin
      if (!rx_bit && zero_run_r + 12'h001 >= zero_limit) begin
        los_r <= 1'b1;
      end else if (win_cnt_r == DENS_WINDOW - 4'h1 &&
                   win_ones_r + {3'h0, rx_bit} >= DENS_MIN_ONES) begin
        los_r <= 1'b0;
      end
    end
  end

  assign los = los_r;

endmodule // los_detect

// ===== verification/line_cfg_props.sv
/*
  Checker for the configuration decoder; sees only the top module's ports.
  Assumes one sys_clk domain with rst as its asynchronous reset.
*/
`timescale 1ns/1ps
module line_cfg_props (
  input wire logic sys_clk,
  input wire logic rst,
  input line_cfg_pkg::cfg_pins_t cfg_pins,
  input line_cfg_pkg::cfg_pins_t reg_cfg,
  input wire logic los_long_criterion,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  input line_cfg_pkg::cfg_decoded_t cfg_out,
  input wire logic [1:0] ctrl_iface,
  input wire logic hw_control,
  input wire logic [11:0] los_zero_limit,
  input wire logic [3:0] rx_latency_ui,
  input wire logic los
);
  import line_cfg_pkg::*;
  // =====================================================================
  // pin stability tracker
  // =====================================================================
  // relations hold only once the three-stage pin pipeline has drained
  cfg_pins_t prev_r;
  logic [2:0] stable_r;
  logic quiet;
  logic settled;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_r <= '0;
      stable_r <= 3'h0;
    end else begin
      prev_r <= cfg_pins;
      if (cfg_pins != prev_r) begin
        stable_r <= 3'h0;
      end else if (stable_r != 3'h7) begin
        stable_r <= stable_r + 3'h1;
      end
    end
  end
  // the edge that first samples new pins still sees the old count
  assign quiet = stable_r >= 3'h4 && cfg_pins == prev_r;
  assign settled = quiet && cfg_pins.ctrl_mode == CTRL_HW;
  // =====================================================================
  // assertions
  // =====================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_mode_follow: assert property (quiet |-> ctrl_iface == cfg_pins.ctrl_mode
    && hw_control == (cfg_pins.ctrl_mode == CTRL_HW)) else $error("mode outputs wrong");
  chk_driver_hiz: assert property (settled |-> cfg_out.driver_enable == !cfg_pins.driver_hiz)
    else $error("driver enable wrong");
  chk_power_down: assert property (settled |-> cfg_out.rx_pd == cfg_pins.receiver_powerdown
    && cfg_out.tx_pd == (cfg_pins.tx_pattern_select == PAT_TX_PD)) else $error("power down wrong");
  chk_loop_edge: assert property (settled |-> cfg_out.loopback == cfg_pins.loopback_select
    && cfg_out.rx_falling_edge == cfg_pins.rx_clock_edge_select) else $error("loop or edge wrong");
  chk_ja_depth: assert property (cfg_out.ja_enable |-> cfg_out.ja_depth ==
    (cfg_out.ja_narrow ? JA_DEPTH_128 : JA_DEPTH_64)) else $error("fifo depth wrong");
  chk_latency_rail: assert property (!cfg_out.ja_enable |-> rx_latency_ui ==
    ((cfg_out.single_rail || cfg_out.slicer) ? LAT_SINGLE_UI : LAT_DUAL_UI))
    else $error("latency wrong");
  chk_los_limit: assert property (if (cfg_out.line_std == STD_E1)
    los_zero_limit inside {LOS_E1_G775, LOS_E1_I431}
    else los_zero_limit inside {LOS_T1_T1231, LOS_T1_I431}) else $error("zero limit wrong");
  chk_los_declare: assert property ($rose(los) |-> $past(rx_bit_valid, 2)
    && !$past(rx_bit, 2)) else $error("los rose without a zero");
  chk_los_clear: assert property ($fell(los) |-> $past(rx_bit_valid, 2))
    else $error("los fell without a bit");
  cover property ($rose(los));
  cover property ($fell(los));
  cover property ($fell(hw_control));
  cover property (cfg_out.ja_in_tx);
endmodule // line_cfg_props

bind line_iface_hw_config_decode line_cfg_props line_cfg_props_inst (
  .sys_clk(sys_clk), .rst(rst), .cfg_pins(cfg_pins), .reg_cfg(reg_cfg),
  .los_long_criterion(los_long_criterion), .rx_bit_valid(rx_bit_valid),
  .rx_bit(rx_bit), .cfg_out(cfg_out), .ctrl_iface(ctrl_iface), .hw_control(hw_control),
  .los_zero_limit(los_zero_limit), .rx_latency_ui(rx_latency_ui), .los(los)
);

// ===== verification/strap_board_model.sv
/*
  Board strap model: holds the configuration pins static between loads.
  Assumes the bench pulses load for one cycle per reconfiguration.
*/
`timescale 1ns/1ps
module strap_board_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input line_cfg_pkg::cfg_pins_t next_pins,
  output line_cfg_pkg::cfg_pins_t pins
);
  import line_cfg_pkg::*;
  // pins move only on a load edge, so decoded settings never glitch
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pins <= '0;
    end else if (load) begin
      pins <= next_pins;
    end
  end
endmodule // strap_board_model

// ===== verification/line_iface_hw_config_decode_tb.sv
/*
  Self-checking bench for the configuration decoder.
  Assumes the strap model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module line_iface_hw_config_decode_tb;
  import line_cfg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst;
  logic load;
  cfg_pins_t next_pins;
  cfg_pins_t cfg_pins;
  cfg_pins_t reg_cfg;
  logic los_long_criterion;
  logic rx_bit_valid;
  logic rx_bit;
  cfg_decoded_t cfg_out;
  logic [1:0] ctrl_iface;
  logic hw_control;
  logic [11:0] los_zero_limit;
  logic [3:0] rx_latency_ui;
  logic los;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  strap_board_model strap_board_model_inst (.sys_clk(sys_clk), .rst(rst), .load(load),
    .next_pins(next_pins), .pins(cfg_pins));
  line_iface_hw_config_decode line_iface_hw_config_decode_inst (.sys_clk(sys_clk),
    .rst(rst), .cfg_pins(cfg_pins), .reg_cfg(reg_cfg), .los_long_criterion(los_long_criterion),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .cfg_out(cfg_out), .ctrl_iface(ctrl_iface),
    .hw_control(hw_control), .los_zero_limit(los_zero_limit), .rx_latency_ui(rx_latency_ui),
    .los(los));
  // =====================================================================
  // shared tasks
  // =====================================================================
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apply(input cfg_pins_t p, input logic lg);
    @(posedge sys_clk);
    next_pins <= p;
    los_long_criterion <= lg;
    load <= 1'b1;
    @(posedge sys_clk);
    load <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // marks land on the last bit of every eight, so no zero run carries over
  task automatic send(input int n, input bit marks);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk);
      rx_bit_valid <= 1'b1;
      rx_bit <= marks && (k % 8 == 7);
    end
    @(posedge sys_clk);
    rx_bit_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // =====================================================================
  // scenarios
  // =====================================================================
  task automatic check_templates();
    cfg_pins_t p;
    logic [11:0] lim;
    p = '0;
    for (int c = 0; c < 16; c++) begin
      p.pulse_template_select = 4'(c);
      apply(p, c[0]);
      settle();
      lim = c[0] ? LOS_T1_I431 : LOS_T1_T1231;
      if (c < 2) begin
        lim = c[0] ? LOS_E1_I431 : LOS_E1_G775;
        cmp("std", STD_E1, cfg_out.line_std);
        cmp("ohms", c[0] ? OHM_120 : OHM_75, cfg_out.term_ohms);
      end else if (c < 7) begin
        cmp("std", STD_DSX1, cfg_out.line_std);
        cmp("ohms", OHM_100, cfg_out.term_ohms);
        cmp("range", 12'(c - 2), cfg_out.dsx1_range);
      end else if (c == 7) begin
        cmp("std", STD_J1, cfg_out.line_std);
        cmp("ohms", OHM_110, cfg_out.term_ohms);
      end else begin
        cmp("std", STD_DS1, cfg_out.line_std);
        cmp("ohms", OHM_100, cfg_out.term_ohms);
        cmp("lbo", c < 12 ? 12'((c - 8) * 15) : 12'h000, cfg_out.lbo_half_db);
      end
      cmp("limit", lim, los_zero_limit);
      cmp("ext_illegal", c > 1, cfg_out.ext_match_illegal);
    end
  endtask
  task automatic check_fields();
    cfg_pins_t p;
    for (int i = 0; i < 4; i++) begin
      p = '0;
      p.termination_internal = 1'b1;
      p.system_iface_format = 2'(i);
      p.tx_pattern_select = 2'(i);
      p.jitter_atten_config = 2'(i);
      p.loopback_select = 2'(i);
      {p.equalizer_reach_select, p.monitor_gain_select, p.rx_clock_edge_select} = {3{i[0]}};
      {p.receiver_powerdown, p.driver_hiz} = {2{i[1]}};
      apply(p, 1'b0);
      settle();
      cmp("ami", i == 1, cfg_out.ami_coding);
      cmp("slicer", i == 3, cfg_out.slicer);
      cmp("single", i < 2, cfg_out.single_rail);
      cmp("latency", i == 2 ? LAT_DUAL_UI : LAT_SINGLE_UI, rx_latency_ui);
      cmp("ones", i == 1, cfg_out.tx_send_ones);
      cmp("prbs", i == 2, cfg_out.tx_send_prbs);
      cmp("tx_pd", i == 3, cfg_out.tx_pd);
      cmp("ja_on", i != 0, cfg_out.ja_enable);
      cmp("ja_tx", i == 3, cfg_out.ja_in_tx);
      cmp("ja_narrow", i > 1, cfg_out.ja_narrow);
      if (i != 0) cmp("depth", i == 1 ? JA_DEPTH_64 : JA_DEPTH_128, cfg_out.ja_depth);
      cmp("loop", 12'(i), cfg_out.loopback);
      cmp("eq", i[0] ? EQ_LONG_DB : EQ_SHORT_DB, cfg_out.eq_reach_db);
      cmp("mon", i[0] ? MON_GAIN_DB : 5'h00, cfg_out.mon_gain_db);
      cmp("fall", i[0], cfg_out.rx_falling_edge);
      cmp("rx_pd", i[1], cfg_out.rx_pd);
      cmp("drv_en", !i[1], cfg_out.driver_enable);
    end
  endtask
  task automatic check_modes();
    cfg_pins_t p;
    p = '0;
    for (int m = 1; m < 4; m++) begin
      p.ctrl_mode = 2'(m);
      apply(p, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1;
      cmp("mode_early", 12'(m - 1), ctrl_iface);
      @(posedge sys_clk);
      #1;
      cmp("mode", 12'(m), ctrl_iface);
      cmp("hw", 0, hw_control);
      settle();
      cmp("reg_pd", 1, cfg_out.rx_pd);
      cmp("reg_lb", LB_REMOTE, cfg_out.loopback);
    end
    p.ctrl_mode = CTRL_HW;
    apply(p, 1'b0);
    settle();
    cmp("hw", 1, hw_control);
    cmp("pin_pd", 0, cfg_out.rx_pd);
  endtask
  task automatic check_los(input logic [3:0] tmpl, input int lim);
    cfg_pins_t p;
    p = '0;
    p.termination_internal = 1'b1;
    p.pulse_template_select = tmpl;
    apply(p, 1'b0);
    settle();
    send(lim - 1, 1'b0);
    cmp("los_early", 0, los);
    send(1, 1'b0);
    cmp("los_set", 1, los);
    send(16, 1'b1);
    cmp("los_clear", 0, los);
  endtask
  // =====================================================================
  // main sequence and watchdog
  // =====================================================================
  initial begin
    rst = 1'b1;
    load = 1'b0;
    next_pins = '0;
    reg_cfg = '0;
    reg_cfg.receiver_powerdown = 1'b1;
    reg_cfg.loopback_select = LB_REMOTE;
    los_long_criterion = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    repeat (15) @(posedge sys_clk);
    #1;
    cmp("rst_std", STD_E1, cfg_out.line_std);
    cmp("rst_limit", LOS_E1_G775, los_zero_limit);
    @(posedge sys_clk);
    rst <= 1'b0;
    check_templates();
    check_fields();
    check_modes();
    check_los(PT_E1_75, 32);
    check_los(PT_J1, 175);
    close_out();
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      close_out();
    end
  end
endmodule // line_iface_hw_config_decode_tb
